// ===== rtl/spi_flash_pin_interface.sv
`timescale 1ns/10ps
`include "spi_flash_cfg.svh"

module spi_flash_pin_interface #(
  parameter logic [7:0] UID_SEED = 8'h5A // arbitrary neutral value
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial pins
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  output logic si_out,
  output logic si_oe_out,
  output logic so_out,
  output logic so_oe_out,
  input wire logic hold_n_in,
  // state
  output logic standby_out,
  output logic mode3_out,
  // array read stream
  output logic rd_en_out,
  output logic [`ADDR_BITS-1:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_data_valid_in,
  output logic rd_data_ready_out,
  // array program data
  output logic wr_valid_out,
  output logic [`ADDR_BITS-1:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  // array operation control
  output logic op_start_out,
  output spi_flash_pkg::array_op_t op_kind_out,
  output logic [`ADDR_BITS-1:0] op_addr_out,
  input wire logic op_busy_in,
  input wire logic op_done_in,
  input wire logic op_fail_in
);
  import spi_flash_pkg::*;

  frame_state_t state_q;
  array_op_t pend_op_q;
  logic cs_prev_q;
  logic sck_prev_q;
  logic hold_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] sh_in_q;
  logic [7:0] opcode_q;
  logic [1:0] addr_cnt_q;
  logic [23:0] addr_q;
  logic [8:0] prog_cnt_q;
  logic [7:0] out_sh_q;
  logic [2:0] out_left_q;
  logic fail_q;
  logic otp_locked_q;
  logic otp_wrote_q;
  logic [7:0] otp_user_q [0:63];
  logic [`OTP_IDX_BITS-1:0] otp_idx;
  logic selected;
  logic cs_fall;
  logic cs_rise;
  logic hold_d;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic [7:0] byte_in;
  logic out_phase;
  logic need_byte;
  logic [7:0] next_byte;
  logic buf_pop;
  logic [7:0] status_byte;

  byte_stream_if fill_if ();
  byte_stream_if drain_if ();

  // helpers for opcode dispatch and the factory OTP read bytes
  function automatic logic is_addr_cmd(input logic [7:0] opc);
    is_addr_cmd = (opc == `OPC_READ) || (opc == `OPC_DUAL_READ) || (opc == `OPC_PROGRAM)
      || (opc == `OPC_ERASE_PAGE) || (opc == `OPC_ERASE_4K) || (opc == `OPC_ERASE_32K)
      || (opc == `OPC_OTP_READ) || (opc == `OPC_OTP_PROGRAM);
  endfunction : is_addr_cmd

  function automatic logic [7:0] uid_byte(input logic [`OTP_IDX_BITS-1:0] idx);
    uid_byte = UID_SEED ^ {1'b0, idx};
  endfunction : uid_byte

  assign selected = ~cs_n_in;
  assign cs_fall = ~cs_n_in & cs_prev_q;
  assign cs_rise = cs_n_in & ~cs_prev_q;
  // a pause can only start with the clock low; it ends whenever the pin is released
  assign hold_d = selected & ~hold_n_in & (hold_q | ~sck_in);
  // sck and si only count while selected and not paused
  assign sck_rise = selected & ~hold_q & ~cs_fall & sck_in & ~sck_prev_q;
  assign sck_fall = selected & ~hold_q & ~cs_fall & ~sck_in & sck_prev_q;
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
  assign byte_in = {sh_in_q[6:0], si_in};
  assign out_phase = (state_q == ST_READ) || (state_q == ST_DUAL)
    || (state_q == ST_STAT) || (state_q == ST_OTP_RD);
  assign need_byte = sck_fall && out_phase && (out_left_q == 3'h0);
  assign otp_idx = addr_q[`OTP_IDX_BITS-1:0];

  always_comb begin
    status_byte = `STATUS_RST;
    status_byte[`STAT_BUSY_BIT] = op_busy_in;
    status_byte[`STAT_OTP_LOCK_BIT] = otp_locked_q;
    status_byte[`STAT_FAIL_BIT] = fail_q;
  end

  always_comb begin
    next_byte = `IDLE_BYTE;
    buf_pop = 1'b0;
    if (state_q == ST_STAT) begin
      next_byte = status_byte;
    end else if (state_q == ST_OTP_RD) begin
      if (otp_idx < `OTP_FACTORY_BYTES) begin
        next_byte = uid_byte(otp_idx);
      end else begin
        next_byte = otp_user_q[otp_idx[5:0]];
      end
    end else if (drain_if.valid) begin
      next_byte = drain_if.data;
      buf_pop = need_byte;
    end
  end

  assign fill_if.data = rd_data_in;
  assign fill_if.valid = rd_data_valid_in & rd_en_out;
  assign rd_data_ready_out = fill_if.ready;
  assign drain_if.ready = buf_pop;

  two_entry_buffer u_read_buffer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .flush_in(cs_rise),
    .fill(fill_if),
    .drain(drain_if)
  );

  // pin history and pause
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
      hold_q <= 1'b0;
      mode3_out <= 1'b0;
    end else begin
      cs_prev_q <= cs_n_in;
      sck_prev_q <= sck_in;
      hold_q <= hold_d;
      if (cs_fall) begin
        mode3_out <= sck_in;
      end
    end
  end

  // input shifter and frame decoder
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cs_rise) begin
      state_q <= ST_CMD;
      bit_cnt_q <= 3'h0;
      sh_in_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_cnt_q <= 2'h0;
      addr_q <= 24'h000000;
      prog_cnt_q <= 9'h000;
      pend_op_q <= OP_NONE;
      rd_en_out <= 1'b0;
    end else if (cs_fall) begin
      state_q <= ST_CMD;
      bit_cnt_q <= 3'h0;
      prog_cnt_q <= 9'h000;
      pend_op_q <= OP_NONE;
    end else begin
      if (sck_rise) begin
        sh_in_q <= byte_in;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (rd_en_out && fill_if.valid && fill_if.ready) begin
        addr_q <= addr_q + 24'h000001;
      end
      if (state_q == ST_OTP_RD && need_byte) begin
        addr_q <= addr_q + 24'h000001;
      end
      if (byte_done) begin
        case (state_q)
          ST_CMD: begin
            opcode_q <= byte_in;
            if (op_busy_in && byte_in != `OPC_READ_STATUS) begin
              state_q <= ST_IGNORE;
            end else if (byte_in == `OPC_READ_STATUS) begin
              state_q <= ST_STAT;
            end else if (byte_in == `OPC_ERASE_CHIP) begin
              state_q <= ST_DONE;
              pend_op_q <= OP_ERASE_CHIP;
            end else if (is_addr_cmd(byte_in)) begin
              state_q <= ST_ADDR;
            end else begin
              state_q <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addr_q <= {addr_q[15:0], byte_in};
            addr_cnt_q <= addr_cnt_q + 2'h1;
            if (addr_cnt_q == 2'h2) begin
              if (opcode_q == `OPC_READ) begin
                state_q <= ST_READ;
                rd_en_out <= 1'b1;
              end else if (opcode_q == `OPC_DUAL_READ) begin
                state_q <= ST_DUMMY;
                rd_en_out <= 1'b1;
              end else if (opcode_q == `OPC_PROGRAM) begin
                state_q <= ST_PROG;
              end else if (opcode_q == `OPC_OTP_READ) begin
                state_q <= ST_OTP_RD;
              end else if (opcode_q == `OPC_OTP_PROGRAM) begin
                state_q <= ST_OTP_PR;
              end else begin
                state_q <= ST_DONE;
                if (opcode_q == `OPC_ERASE_PAGE) begin
                  pend_op_q <= OP_ERASE_PAGE;
                end else if (opcode_q == `OPC_ERASE_4K) begin
                  pend_op_q <= OP_ERASE_4K;
                end else begin
                  pend_op_q <= OP_ERASE_32K;
                end
              end
            end
          end
          ST_DUMMY: begin
            state_q <= ST_DUAL;
          end
          ST_PROG: begin
            if (prog_cnt_q != `PAGE_BYTES) begin
              prog_cnt_q <= prog_cnt_q + 9'h001;
              pend_op_q <= OP_PROGRAM;
              addr_q[7:0] <= addr_q[7:0] + 8'h01;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // program bytes go to the array as they arrive; the page index wraps, the count caps
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_valid_out <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= 8'h00;
    end else begin
      wr_valid_out <= byte_done && (state_q == ST_PROG) && (prog_cnt_q != `PAGE_BYTES);
      if (byte_done) begin
        wr_addr_out <= addr_q[`ADDR_BITS-1:0];
        wr_data_out <= byte_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_addr_out <= '0;
    end else begin
      rd_addr_out <= addr_q[`ADDR_BITS-1:0];
    end
  end

  // internal cycles start only at the closing edge of the frame
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      op_start_out <= 1'b0;
      op_kind_out <= OP_NONE;
      op_addr_out <= '0;
      fail_q <= 1'b0;
    end else begin
      op_start_out <= cs_rise && (pend_op_q != OP_NONE) && !op_busy_in;
      if (cs_rise && (pend_op_q != OP_NONE) && !op_busy_in) begin
        op_kind_out <= pend_op_q;
        op_addr_out <= addr_q[`ADDR_BITS-1:0];
      end
      if (op_done_in && op_fail_in) begin
        fail_q <= 1'b1;
      end else if (op_start_out) begin
        fail_q <= 1'b0;
      end
    end
  end

  // user half of the security area; the factory half is fixed logic
  generate
    for (genvar i = 0; i < 64; i++) begin : g_otp_user
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          otp_user_q[i] <= `OTP_USER_RST;
        end else if (byte_done && state_q == ST_OTP_PR && !otp_locked_q
                     && otp_idx >= `OTP_FACTORY_BYTES && otp_idx[5:0] == 6'(i)) begin
          otp_user_q[i] <= byte_in;
        end
      end
    end
  endgenerate

  // lock is not kept across reset here; a real part keeps it in the array
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      otp_locked_q <= 1'b0;
      otp_wrote_q <= 1'b0;
    end else if (cs_rise) begin
      otp_locked_q <= otp_locked_q | otp_wrote_q;
      otp_wrote_q <= 1'b0;
    end else if (byte_done && state_q == ST_OTP_PR && !otp_locked_q) begin
      otp_wrote_q <= 1'b1;
    end
  end

  // output shifter; pins only move on falling clock edges
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !selected) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      si_out <= 1'b0;
      si_oe_out <= 1'b0;
      out_sh_q <= 8'h00;
      out_left_q <= 3'h0;
    end else begin
      if (hold_d) begin
        so_oe_out <= 1'b0;
        si_oe_out <= 1'b0;
      end else if (out_phase && out_left_q != 3'h0) begin
        so_oe_out <= 1'b1;
        si_oe_out <= (state_q == ST_DUAL);
      end
      if (need_byte) begin
        so_oe_out <= ~hold_d;
        if (state_q == ST_DUAL) begin
          so_out <= next_byte[7];
          si_out <= next_byte[6];
          si_oe_out <= ~hold_d;
          out_sh_q <= {next_byte[5:0], 2'b00};
          out_left_q <= 3'h3;
        end else begin
          so_out <= next_byte[7];
          out_sh_q <= {next_byte[6:0], 1'b0};
          out_left_q <= 3'h7;
        end
      end else if (sck_fall && out_phase) begin
        if (state_q == ST_DUAL) begin
          so_out <= out_sh_q[7];
          si_out <= out_sh_q[6];
          out_sh_q <= {out_sh_q[5:0], 2'b00};
        end else begin
          so_out <= out_sh_q[7];
          out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
        out_left_q <= out_left_q - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      standby_out <= 1'b1;
    end else begin
      // a pending op at the closing edge keeps standby off until busy takes over
      standby_out <= cs_n_in && !op_busy_in && !op_start_out
        && (pend_op_q == OP_NONE);
    end
  end

endmodule : spi_flash_pin_interface

// ===== rtl/spi_flash_cfg.svh
`ifndef SPI_FLASH_CFG_SVH
`define SPI_FLASH_CFG_SVH

// opcodes
`define OPC_READ 8'h03
`define OPC_DUAL_READ 8'h3B
`define OPC_PROGRAM 8'h02
`define OPC_ERASE_PAGE 8'h81
`define OPC_ERASE_4K 8'h20
`define OPC_ERASE_32K 8'h52
`define OPC_ERASE_CHIP 8'h60
`define OPC_READ_STATUS 8'h05
`define OPC_OTP_READ 8'h77
`define OPC_OTP_PROGRAM 8'h9B

// geometry
`define ADDR_BITS 17
`define PAGE_BYTES 9'h100
`define OTP_BYTES 8'h80
`define OTP_FACTORY_BYTES 7'h40
`define OTP_IDX_BITS 7

// status byte layout
`define STAT_BUSY_BIT 0
`define STAT_OTP_LOCK_BIT 1
`define STAT_FAIL_BIT 5

// reset values
`define STATUS_RST 8'h00
`define OTP_USER_RST 8'hFF
`define IDLE_BYTE 8'hFF

`endif

// ===== rtl/spi_flash_pkg.sv
package spi_flash_pkg;

  typedef enum logic [3:0] {
    ST_CMD = 4'h0,
    ST_ADDR = 4'h1,
    ST_DUMMY = 4'h2,
    ST_READ = 4'h3,
    ST_DUAL = 4'h4,
    ST_PROG = 4'h5,
    ST_STAT = 4'h6,
    ST_OTP_RD = 4'h7,
    ST_OTP_PR = 4'h8,
    ST_DONE = 4'h9,
    ST_IGNORE = 4'hA
  } frame_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_ERASE_PAGE = 3'h2,
    OP_ERASE_4K = 3'h3,
    OP_ERASE_32K = 3'h4,
    OP_ERASE_CHIP = 3'h5
  } array_op_t;

endpackage : spi_flash_pkg

// ===== rtl/byte_stream_if.sv
`timescale 1ns/10ps
interface byte_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// ===== rtl/two_entry_buffer.sv
`timescale 1ns/10ps
module two_entry_buffer (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // streams
  byte_stream_if.snk fill,
  byte_stream_if.src drain
);
  import spi_flash_pkg::*;

  logic [7:0] mem_q [0:1];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic in_ready_q;
  logic out_valid_q;
  logic push;
  logic pop;

  assign push = fill.valid & in_ready_q;
  assign pop = drain.ready & out_valid_q;
  assign fill.ready = in_ready_q;
  assign drain.valid = out_valid_q;
  assign drain.data = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || flush_in) begin
      count_q <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      in_ready_q <= (count_d != 2'h2);
      out_valid_q <= (count_d != 2'h0);
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= fill.data;
    end
  end

endmodule : two_entry_buffer

// ===== dv/spi_flash_pin_monitor.sv
`timescale 1ns/10ps
module spi_flash_pin_monitor (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // serial pins
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic hold_n_in,
  input wire logic si_oe_out,
  input wire logic so_out,
  input wire logic so_oe_out,
  // state and array side
  input wire logic standby_out,
  input wire logic mode3_out,
  input wire logic wr_valid_out,
  input wire logic op_start_out,
  input wire logic op_busy_in
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  a_deselect_float:
    assert property ($past(cs_n_in, 2) && $past(cs_n_in) |-> !so_oe_out && !si_oe_out)
    else $error("output driven while deselected");
  a_deselect_deaf:
    assert property ($past(cs_n_in, 2) && $past(cs_n_in) |-> !wr_valid_out)
    else $error("data taken while deselected");
  a_select_active:
    assert property (!cs_n_in && $past(!cs_n_in) |-> !standby_out)
    else $error("standby while selected");
  a_busy_no_standby:
    assert property (op_busy_in && $past(op_busy_in) |-> !standby_out)
    else $error("standby during internal cycle");
  a_out_on_fall:
    assert property (so_oe_out && $past(so_oe_out) && $changed(so_out) |-> !sck_in)
    else $error("output changed near a rising clock");
  a_dual_lanes:
    assert property (si_oe_out |-> so_oe_out)
    else $error("lane zero driven without lane one");
  a_write_on_rise:
    assert property (wr_valid_out |-> sck_in && !cs_n_in)
    else $error("write byte not after a rising clock");
  a_start_at_rise:
    assert property (op_start_out |-> $past(cs_n_in) && !$past(op_start_out))
    else $error("operation start not on chip select rise");
  a_hold_floats:
    assert property (!hold_n_in && $past(!hold_n_in) && $past(!hold_n_in, 2) |-> !so_oe_out)
    else $error("output driven during hold");
  a_mode_capture:
    assert property ($fell(cs_n_in) |-> ##3 mode3_out == sck_in)
    else $error("mode not taken from idle clock");
  a_start_no_standby:
    assert property (op_start_out |-> !standby_out)
    else $error("standby while an internal cycle starts");

  c_program: cover property (op_start_out);
  c_dual: cover property (si_oe_out);
  c_hold: cover property (!hold_n_in && so_oe_out);
  c_mode3: cover property ($rose(mode3_out));
endmodule : spi_flash_pin_monitor

bind spi_flash_pin_interface spi_flash_pin_monitor spi_flash_pin_monitor_i (.*);

// ===== dv/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
  // clock
  input wire logic ref_clk_in,
  // device driven lanes
  input wire logic lane0_in,
  input wire logic lane0_oe_in,
  input wire logic so_in,
  // host driven pins
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  output logic hold_n_out
);
  logic si_q = 1'b1;
  logic en_q = 1'b1;
  logic mode3_q = 1'b0;

  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    hold_n_out = 1'b1;
  end

  // a released lane shows the inverse of its last bit so a stale value cannot pass
  assign si_out = lane0_oe_in ? lane0_in : (en_q ? si_q : ~si_q);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : wait_clk

  task automatic start(input logic m3);
    wait_clk(1);
    sck_out <= m3;
    mode3_q <= m3;
    wait_clk(4);
    cs_n_out <= 1'b0;
    wait_clk(4);
  endtask : start

  task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
    rx = 8'h00;
    en_q <= !dual;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      sck_out <= 1'b0;
      si_q <= tx[7 - i];
      wait_clk(4);
      sck_out <= 1'b1;
      rx = dual ? {rx[5:0], so_in, lane0_in} : {rx[6:0], so_in};
      wait_clk(4);
    end
  endtask : xfer

  task automatic pause(input int n);
    sck_out <= 1'b0;
    wait_clk(4);
    hold_n_out <= 1'b0;
    wait_clk(n);
    hold_n_out <= 1'b1;
    wait_clk(2);
  endtask : pause

  task automatic stop;
    sck_out <= mode3_q;
    en_q <= 1'b1;
    wait_clk(4);
    cs_n_out <= 1'b1;
    wait_clk(8);
  endtask : stop
endmodule : spi_host_model

// ===== dv/tb_spi_flash_pin_interface.sv
`timescale 1ns/10ps
`include "spi_flash_cfg.svh"
module tb_spi_flash_pin_interface;
  import spi_flash_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n, sck, si, hold_n, si_o, si_oe, so, so_oe, standby, mode3;
  logic rd_en, rd_ready, wr_valid, op_start, busy, op_fail, rd_valid, done_q;
  logic fail_mode = 1'b0;
  logic [`ADDR_BITS-1:0] rd_addr, wr_addr, op_addr;
  logic [7:0] wr_data, rx, rd_data;
  array_op_t op_kind;
  logic [8:0] busy_cnt;
  logic [31:0] lfsr_q = 32'h920B0695;
  logic [28:0] exp_q[$];
  logic [28:0] msk_q[$];
  int error_cnt = 0;
  int cmp_count = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  spi_host_model spi_host_model_i (.ref_clk_in(ref_clk_in), .lane0_in(si_o),
    .lane0_oe_in(si_oe), .so_in(so), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
    .hold_n_out(hold_n));

  spi_flash_pin_interface spi_flash_pin_interface_i (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si), .si_out(si_o),
    .si_oe_out(si_oe), .so_out(so), .so_oe_out(so_oe), .hold_n_in(hold_n),
    .standby_out(standby), .mode3_out(mode3), .rd_en_out(rd_en), .rd_addr_out(rd_addr),
    .rd_data_in(rd_data), .rd_data_valid_in(rd_valid),
    .rd_data_ready_out(rd_ready), .wr_valid_out(wr_valid), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .op_start_out(op_start), .op_kind_out(op_kind),
    .op_addr_out(op_addr), .op_busy_in(busy), .op_done_in(done_q), .op_fail_in(op_fail));

  // array byte is a fixed function of its address
  assign rd_data = rd_addr[7:0] ^ 8'hA5;
  assign busy = busy_cnt != 9'h000;
  assign op_fail = done_q && fail_mode;

  // array: the read address lags one cycle, so valid follows each new address a
  // cycle later; busy 200 cycles per op
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_valid <= 1'b0;
      busy_cnt <= 9'h000;
      done_q <= 1'b0;
    end else begin
      rd_valid <= rd_en && !(rd_valid && rd_ready);
      busy_cnt <= op_start ? 9'd200 : busy_cnt - (busy_cnt != 9'h000);
      done_q <= busy_cnt == 9'h001;
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic print_verdict;
    error_cnt += exp_q.size();
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask : chk_byte

  task automatic chk_arr(input logic [28:0] got);
    logic [28:0] e, m;
    cmp_count++;
    e = exp_q.size() ? exp_q.pop_front() : ~got;
    m = msk_q.size() ? msk_q.pop_front() : '1;
    if ((got & m) !== (e & m)) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask : chk_arr

  always @(posedge ref_clk_in) begin
    if (wr_valid) chk_arr({4'h0, wr_addr, wr_data});
    if (op_start) chk_arr({1'b1, op_kind, op_addr, 8'h00});
  end

  task automatic note(input logic [28:0] e, input logic [28:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask : note

  task automatic send(input logic [7:0] b);
    spi_host_model_i.xfer(b, 1'b0, rx);
  endtask : send

  task automatic cmd_addr(input logic [7:0] op, input logic [23:0] a);
    send(op);
    send(a[23:16]);
    send(a[15:8]);
    send(a[7:0]);
  endtask : cmd_addr

  task automatic status(input logic m3, input logic [7:0] e);
    spi_host_model_i.start(m3);
    send(8'h05);
    send(8'hFF);
    chk_byte(rx, e);
    spi_host_model_i.stop();
  endtask : status

  task automatic wait_idle;
    int k;
    k = 0;
    while (standby !== 1'b1 && k < 400) begin
      @(posedge ref_clk_in);
      k++;
    end
    chk_byte({7'h00, standby}, 8'h01);
  endtask : wait_idle

  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    send(8'h02);
    status(1'b0, 8'h00);
    spi_host_model_i.start(1'b0);
    send(8'h02);
    send(8'h12);
    spi_host_model_i.stop();
    status(1'b0, 8'h00);
    spi_host_model_i.start(1'b0);
    cmd_addr(8'h02, 24'h0012FE);
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      note({4'h0, 9'h012, 8'hFE + i[7:0], lfsr_q[7:0]}, '1);
      send(lfsr_q[7:0]);
    end
    note({1'b1, OP_PROGRAM, 17'h01201, 8'h00}, '1);
    spi_host_model_i.stop();
    status(1'b0, 8'h01);
    wait_idle();
    spi_host_model_i.start(1'b0);
    cmd_addr(8'h77, 24'h000000);
    send(8'hFF);
    chk_byte(rx, 8'h5A);
    send(8'hFF);
    chk_byte(rx, 8'h5B);
    spi_host_model_i.stop();
    spi_host_model_i.start(1'b0);
    cmd_addr(8'h03, 24'h000010);
    send(8'hFF);
    chk_byte(rx, 8'hB5);
    send(8'hFF);
    chk_byte(rx, 8'hB4);
    spi_host_model_i.stop();
    spi_host_model_i.start(1'b0);
    cmd_addr(8'h3B, 24'h000020);
    send(8'hFF);
    for (int i = 0; i < 2; i++) begin
      spi_host_model_i.xfer(8'h00, 1'b1, rx);
      chk_byte(rx, 8'h85 - i[7:0]);
    end
    spi_host_model_i.stop();
    for (int i = 0; i < 4; i++) begin
      fail_mode <= i == 3;
      spi_host_model_i.start(1'b0);
      if (i < 3) cmd_addr(i == 0 ? 8'h81 : (i == 1 ? 8'h20 : 8'h52), 24'h012345);
      else send(8'h60);
      note({1'b1, array_op_t'(i + 2), 17'h12345, 8'h00},
        i < 3 ? '1 : 29'h1E000000);
      spi_host_model_i.stop();
      wait_idle();
    end
    status(1'b1, 8'h20);
    spi_host_model_i.start(1'b0);
    send(8'h05);
    spi_host_model_i.pause(6);
    send(8'hFF);
    chk_byte(rx, 8'h20);
    spi_host_model_i.stop();
    // user half written once; the second frame finds it locked
    lfsr_q = lfsr_next(lfsr_q);
    for (int i = 0; i < 2; i++) begin
      spi_host_model_i.start(1'b0);
      cmd_addr(8'h9B, 24'h000040);
      send(lfsr_q[7:0] ^ {8{i[0]}});
      spi_host_model_i.stop();
    end
    spi_host_model_i.start(1'b0);
    cmd_addr(8'h77, 24'h000040);
    send(8'hFF);
    chk_byte(rx, lfsr_q[7:0]);
    spi_host_model_i.stop();
    status(1'b0, 8'h22);
    print_verdict();
  end
endmodule : tb_spi_flash_pin_interface
